// file: dplc_pkg.sv
// Package for the decoder pin and loop configuration register bank
`default_nettype none
package dplc_pkg;

  // Register index space and APB framing
  localparam int unsigned      IDX_W       = 4;           // Printed register address width
  localparam int unsigned      APB_AW      = 8;           // Byte address width seen by the slave
  localparam int unsigned      DATA_W      = 32;          // APB data width
  localparam int unsigned      REG_W       = 4;           // Stored register width
  localparam int unsigned      BYTE_SHIFT  = 2;           // Byte address is four times the index

  // Main decoder register indices held here
  localparam logic [IDX_W-1:0] IDX_LOOP    = 4'h8;        // pll_loop_filter_bandwidth
  localparam logic [IDX_W-1:0] IDX_OFFMUTE = 4'hc;        // versatile_pins_offtrack_mute
  localparam logic [IDX_W-1:0] IDX_MOTSUB  = 4'hd;        // versatile_pins_motor_subcode
  localparam logic [IDX_W-1:0] IDX_AUDIO   = 4'he;        // audio_lock_brake_config
  localparam logic [IDX_W-1:0] IDX_SUBSHD  = 4'hf;        // subcode_and_shadow_enable
  // Shadow register indices held here
  localparam logic [IDX_W-1:0] IDX_SHCLK   = 4'h3;        // shadow_clock_pin_control
  // Pin status word, outside both index spaces
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h40;      // Always decoded

  // Reset values
  localparam logic [REG_W-1:0] RST_LOOP    = 4'h9;
  localparam logic [REG_W-1:0] RST_OFFMUTE = 4'h2;
  localparam logic [REG_W-1:0] RST_MOTSUB  = 4'hf;
  localparam logic [REG_W-1:0] RST_AUDIO   = 4'h4;
  localparam logic [REG_W-1:0] RST_SUBSHD  = 4'h0;
  localparam logic [REG_W-1:0] RST_SHCLK   = 4'h0;

  // Field positions
  localparam int unsigned      B_OFF_EXT   = 0;           // Off-track from versatile_pin_one
  localparam int unsigned      B_MUTE_ONE  = 1;           // Single combined mute output
  localparam int unsigned      B_PIN3_LVL  = 2;           // Level of versatile_pin_three
  localparam int unsigned      B_LOCK      = 1;           // Lock-to-disc enable
  localparam int unsigned      B_BRAKE6    = 0;           // Six percent braking
  localparam int unsigned      B_SHADOW    = 0;           // shadow_space_select
  localparam int unsigned      B_SUB_ON    = 2;           // Subcode interface on
  localparam int unsigned      B_SUB_3W    = 3;           // Three-wire subcode format
  localparam int unsigned      B_CLK_SEL   = 0;           // eleven_unit_clock on shared output
  localparam int unsigned      B_CLK_HIZ   = 1;           // shared_clock_output high impedance
  localparam int unsigned      B_C16_HIZ   = 2;           // sixteen_unit_clock_output high impedance
  localparam int unsigned      B_PIN23_OUT = 3;           // Shared pin as open-drain output
  localparam int unsigned      ST_PIN1     = 0;           // Status: filtered versatile_pin_one
  localparam int unsigned      ST_PIN2     = 1;           // Status: filtered versatile_pin_two
  localparam int unsigned      ST_SHADOW   = 2;           // Status: shadow space active

  // Two-bit pin selector and audio codes, four-bit motor mode code
  localparam logic [1:0]       SEL_STREAM  = 2'h1;        // Pin carries a data stream
  localparam logic [1:0]       SEL_LOW     = 2'h2;        // Pin held low
  localparam logic [1:0]       SEL_HIGH    = 2'h3;        // Pin held high
  localparam logic [1:0]       AUD_ON      = 2'h1;        // Audio features enabled
  localparam logic [REG_W-1:0] MOTOR4_CODE = 4'h0;        // Four-line motor drive

  // APB request and answer carriers
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } dplc_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } dplc_apb_rsp_t;

  // Filter state of one pin synchroniser
  typedef enum logic [1:0] {
    DPLC_SYNC_LOW  = 2'b00,
    DPLC_SYNC_HIGH = 2'b01
  } dplc_level_t;

endpackage
`default_nettype wire

// file: dplc_config_regs.sv
// Pin multiplexing, loop filter and shadow clock-pin configuration register bank
//
// Behaviour
// - Bit0 of C set: off-track from pin one
// - Bit0 clear: internal off-track, pin one readable
// - C bit1 clear: left mute out, right on three
// - Codes 010/110: combined mute, pin three low/high
// - D equal 0000: four-line motor on four, five
// - D bits1..0 steer pin four
// - D bits3..2 steer pin five, de-emphasis bypass
// - Shadow select clear: main register decode
// - Shadow select set: later addresses hit shadow, except index F
// - Register 8 holds loop filter code
// - Shadow 3 bit0 picks shared clock source
// - Shadow 3 bit1 floats shared clock pin
// - Shadow 3 bit2 floats sixteen-unit clock pin
// - Shadow 3 bit3 makes shared pin open-drain
// - All fields take reset values at reset
//
// The implementer's own choice: the APB interface to the registers.
`default_nettype none
module dplc_config_regs
  import dplc_pkg::*;
(
  input  wire logic                clk,                   // 125 MHz system clock
  input  wire logic                rst,                   // Synchronous, active high
  input  wire dplc_apb_req_t       apbReq,                // APB request from master
  output dplc_apb_rsp_t            apbRsp,                // APB answer
  input  wire logic                versatilePinOne,       // Pin one level, asynchronous
  input  wire logic                versatilePinTwoIn,     // Shared two/three pin level, asynchronous
  output logic                     versatilePinThreeOut,  // Shared pin driven value
  output logic                     versatilePinThreeOe,   // Shared pin drive enable
  output logic                     versatilePinFour,      // Pin four value
  output logic                     versatilePinFive,      // Pin five value
  input  wire logic                offTrackInternal,      // Internally generated off-track
  output logic                     offTrack,              // Off-track used by the servo
  input  wire logic                muteLeft,              // Left-channel mute flag
  input  wire logic                muteRight,             // Right-channel mute flag
  input  wire logic                muteBoth,              // Combined mute flag
  output logic                     muteOut,               // Mute output pin
  input  wire logic                motorLineA,            // Extra motor drive line A
  input  wire logic                motorLineB,            // Extra motor drive line B
  input  wire logic                subcodeStream,         // Q-to-W subcode stream
  input  wire logic                deemphasisFlag,        // De-emphasis indication
  output logic                     deemphasisBypass,      // Internal de-emphasis filter off
  output logic                     motorFourLine,         // Four-line motor mode active
  output logic                     audioFeaturesOn,       // Audio features enabled
  output logic                     lockToDisc,            // Lock-to-disc mode enabled
  output logic                     brakeSixPercent,       // Braking at six percent
  output logic                     subcodeOn,             // Subcode interface enabled
  output logic                     subcodeThreeWire,      // Three-wire subcode format
  output logic [1:0]               loopBandwidthSel,      // Loop bandwidth selector
  output logic [1:0]               internalBandScale,     // Internal bandwidth scale
  input  wire logic                quarterRateClock,      // Quarter-rate clock source
  input  wire logic                elevenUnitClock,       // Eleven-unit clock source
  input  wire logic                sixteenUnitClock,      // Sixteen-unit clock source
  output logic                     sharedClockOut,        // shared_clock_output value
  output logic                     sharedClockOe,         // shared_clock_output drive enable
  output logic                     sixteenUnitClockOut,   // sixteen_unit_clock_output value
  output logic                     sixteenUnitClockOe     // sixteen_unit_clock_output drive enable
);

  // Index of an aligned word address
  function automatic logic [IDX_W-1:0] addrIndex(input logic [APB_AW-1:0] a);
    addrIndex = a[BYTE_SHIFT +: IDX_W];
  endfunction

  // True when the address is word aligned and in the 4-bit index space
  function automatic logic inIndexSpace(input logic [APB_AW-1:0] a);
    inIndexSpace = (a[BYTE_SHIFT-1:0] == '0) && (a[APB_AW-1:BYTE_SHIFT+IDX_W] == '0);
  endfunction

  // Glitch filter step: follow once second and third stage agree
  function automatic dplc_level_t filterStep(input dplc_level_t cur, input logic s2, input logic s3);
    // Disagreeing stages hold the old level
    if (s2 == s3) begin
      filterStep = s3 ? DPLC_SYNC_HIGH : DPLC_SYNC_LOW;
    end else begin
      filterStep = cur;
    end
  endfunction

  // Stored registers
  logic [REG_W-1:0] loopReg_q,    loopReg_d;             // pll_loop_filter_bandwidth
  logic [REG_W-1:0] offMuteReg_q, offMuteReg_d;          // versatile_pins_offtrack_mute
  logic [REG_W-1:0] motSubReg_q,  motSubReg_d;           // versatile_pins_motor_subcode
  logic [REG_W-1:0] audioReg_q,   audioReg_d;            // audio_lock_brake_config
  logic [REG_W-1:0] subShdReg_q,  subShdReg_d;           // subcode_and_shadow_enable

  // Shadow space
  logic [REG_W-1:0] shClkReg_q,   shClkReg_d;            // shadow_clock_pin_control

  // Pin synchronisers, three stages each
  logic             pinOneS1_q, pinOneS2_q, pinOneS3_q;  // Pin one chain
  logic             pinTwoS1_q, pinTwoS2_q, pinTwoS3_q;  // Shared pin chain

  dplc_level_t      pinOneLvl_q, pinOneLvl_d;            // Filtered pin one
  dplc_level_t      pinTwoLvl_q, pinTwoLvl_d;            // Filtered shared pin

  // Bus decode
  logic             access;                               // Access phase of a transfer
  logic             wrStrobe;                             // Write takes effect this edge
  logic             shadowActive;                         // Shadow space selected
  logic [IDX_W-1:0] idx;                                  // Register index of address
  logic             isStatus;                             // Status word addressed
  logic             hitLoop, hitOffMute, hitMotSub, hitAudio, hitSubShd, hitShClk;
  logic             mapped;                               // Any register addressed
  logic [REG_W-1:0] wrData;                               // Low nibble of write data

  logic [DATA_W-1:0] rdData;                              // Read mux result

  // Address decode against the active index space
  always_comb begin
    access       = apbReq.psel && apbReq.penable;
    shadowActive = subShdReg_q[B_SHADOW];
    idx          = addrIndex(apbReq.paddr);
    isStatus     = (apbReq.paddr == ADDR_STATUS);
    wrData       = apbReq.pwdata[REG_W-1:0];

    // No word is hit by default
    hitLoop      = 1'b0;
    hitOffMute   = 1'b0;
    hitMotSub    = 1'b0;
    hitAudio     = 1'b0;
    hitSubShd    = 1'b0;
    hitShClk     = 1'b0;

    // Misaligned words stay unmapped
    if (inIndexSpace(apbReq.paddr)) begin
      if (!shadowActive) begin
        hitLoop    = (idx == IDX_LOOP);
        hitOffMute = (idx == IDX_OFFMUTE);
        hitMotSub  = (idx == IDX_MOTSUB);
        hitAudio   = (idx == IDX_AUDIO);
        hitSubShd  = (idx == IDX_SUBSHD);
      end else begin
        hitShClk   = (idx == IDX_SHCLK);

        // Index F stays reachable so software can leave the shadow space
        hitSubShd  = (idx == IDX_SUBSHD);
      end
    end

    mapped   = hitLoop || hitOffMute || hitMotSub || hitAudio
               || hitSubShd || hitShClk || isStatus;
    // Unmapped writes are dropped
    wrStrobe = access && apbReq.pwrite && mapped;
  end

  // Register next values; status word is read-only
  always_comb begin
    loopReg_d    = loopReg_q;
    offMuteReg_d = offMuteReg_q;
    motSubReg_d  = motSubReg_q;
    audioReg_d   = audioReg_q;
    subShdReg_d  = subShdReg_q;
    shClkReg_d   = shClkReg_q;

    if (rst) begin
      // Reset wins over a same-cycle write
      loopReg_d    = RST_LOOP;
      offMuteReg_d = RST_OFFMUTE;
      motSubReg_d  = RST_MOTSUB;
      audioReg_d   = RST_AUDIO;
      subShdReg_d  = RST_SUBSHD;
      shClkReg_d   = RST_SHCLK;
    end else if (wrStrobe) begin
      if (hitLoop) begin
        loopReg_d = wrData;
      end

      if (hitOffMute) begin
        offMuteReg_d = wrData;
      end

      if (hitMotSub) begin
        motSubReg_d = wrData;
      end

      if (hitAudio) begin
        audioReg_d = wrData;
      end

      if (hitSubShd) begin
        subShdReg_d = wrData;
      end

      if (hitShClk) begin
        shClkReg_d = wrData;
      end
    end
  end

  // Register storage
  // Reset values arrive through the _d logic
  always_ff @(posedge clk) begin
    loopReg_q    <= loopReg_d;
    offMuteReg_q <= offMuteReg_d;
    motSubReg_q  <= motSubReg_d;
    audioReg_q   <= audioReg_d;
    subShdReg_q  <= subShdReg_d;

    shClkReg_q   <= shClkReg_d;
  end

  // Filter next values; reset assumes a low pin
  always_comb begin
    if (rst) begin
      pinOneLvl_d = DPLC_SYNC_LOW;
      pinTwoLvl_d = DPLC_SYNC_LOW;
    end else begin
      // Follow the chain once it settles
      pinOneLvl_d = filterStep(pinOneLvl_q, pinOneS2_q, pinOneS3_q);
      pinTwoLvl_d = filterStep(pinTwoLvl_q, pinTwoS2_q, pinTwoS3_q);
    end
  end

  // Synchroniser chains; first stage feeds only the second
  always_ff @(posedge clk) begin
    pinOneS1_q  <= versatilePinOne;
    pinOneS2_q  <= pinOneS1_q;
    pinOneS3_q  <= pinOneS2_q;

    pinTwoS1_q  <= versatilePinTwoIn;
    pinTwoS2_q  <= pinTwoS1_q;
    pinTwoS3_q  <= pinTwoS2_q;
  end

  // Filtered levels
  always_ff @(posedge clk) begin
    pinOneLvl_q <= pinOneLvl_d;
    pinTwoLvl_q <= pinTwoLvl_d;
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rdData = '0;

    if (isStatus) begin
      rdData[ST_PIN1]   = (pinOneLvl_q == DPLC_SYNC_HIGH);
      rdData[ST_PIN2]   = (pinTwoLvl_q == DPLC_SYNC_HIGH);
      rdData[ST_SHADOW] = shadowActive;
    end else if (hitLoop) begin
      rdData[REG_W-1:0] = loopReg_q;
    end else if (hitOffMute) begin
      rdData[REG_W-1:0] = offMuteReg_q;
    end else if (hitMotSub) begin
      rdData[REG_W-1:0] = motSubReg_q;
    end else if (hitAudio) begin
      rdData[REG_W-1:0] = audioReg_q;
    end else if (hitSubShd) begin
      rdData[REG_W-1:0] = subShdReg_q;
    end else if (hitShClk) begin
      rdData[REG_W-1:0] = shClkReg_q;
    end
  end

  // Zero-wait answer; error flags only the unmapped access phase
  always_comb begin
    // Never stretches the access phase
    apbRsp.pready  = 1'b1;
    apbRsp.pslverr = access && !mapped;

    apbRsp.prdata  = rdData;
  end

  // Off-track source and mute routing
  always_comb begin
    if (offMuteReg_q[B_OFF_EXT]) begin
      offTrack = (pinOneLvl_q == DPLC_SYNC_HIGH);
    end else begin
      offTrack = offTrackInternal;
    end

    // Bit 3 of this word is unused
    if (!offMuteReg_q[B_MUTE_ONE]) begin
      muteOut              = muteLeft;
      versatilePinThreeOut = muteRight;
    end else begin
      muteOut              = muteBoth;
      versatilePinThreeOut = offMuteReg_q[B_PIN3_LVL];
    end
  end

  // Shared two/three pin: input unless open-drain output chosen
  always_comb begin
    // Open drain only pulls low; a high level is left to the pull-up
    versatilePinThreeOe = shClkReg_q[B_PIN23_OUT] && !versatilePinThreeOut;
  end

  // Pins four and five, motor and de-emphasis
  always_comb begin
    motorFourLine    = (motSubReg_q == MOTOR4_CODE);

    deemphasisBypass = 1'b0;

    if (motorFourLine) begin
      versatilePinFour = motorLineA;
      versatilePinFive = motorLineB;
    end else begin
      unique case (motSubReg_q[1:0])
        SEL_STREAM: versatilePinFour = subcodeStream;
        SEL_LOW:    versatilePinFour = 1'b0;
        SEL_HIGH:   versatilePinFour = 1'b1;
        default:    versatilePinFour = 1'b0;              // Code 00 outside motor mode
      endcase

      unique case (motSubReg_q[3:2])
        SEL_STREAM: begin
          versatilePinFive = deemphasisFlag;
          deemphasisBypass = 1'b1;
        end
        SEL_LOW:    versatilePinFive = 1'b0;
        SEL_HIGH:   versatilePinFive = 1'b1;
        default:    versatilePinFive = 1'b0;              // Code 00 outside motor mode
      endcase
    end
  end

  // Plain configuration outputs
  always_comb begin
    audioFeaturesOn   = (audioReg_q[3:2] == AUD_ON);
    lockToDisc        = audioReg_q[B_LOCK];
    brakeSixPercent   = audioReg_q[B_BRAKE6];

    subcodeOn         = subShdReg_q[B_SUB_ON];
    subcodeThreeWire  = subShdReg_q[B_SUB_3W];

    loopBandwidthSel  = loopReg_q[1:0];
    internalBandScale = loopReg_q[3:2];
  end

  // Clock pins; clocks are passed through a plain mux, not retimed
  always_comb begin
    sharedClockOut      = shClkReg_q[B_CLK_SEL] ? elevenUnitClock
                                                : quarterRateClock;
    sharedClockOe       = !shClkReg_q[B_CLK_HIZ];

    // Sixteen-unit clock passes straight through
    sixteenUnitClockOut = sixteenUnitClock;
    sixteenUnitClockOe  = !shClkReg_q[B_C16_HIZ];
  end

endmodule
`default_nettype wire

// file: dplc_note_end.sv
// Holds no logic
`default_nettype none
`default_nettype wire

// file: dplc_config_regs_asserts.sv
// Checker bound to the configuration register bank
`default_nettype none
module dplc_config_regs_asserts
  import dplc_pkg::*;
(
  input wire logic          clk, rst, offTrackInternal, offTrack, muteLeft, muteRight, muteBoth, muteOut,
  input wire logic          versatilePinThreeOe, versatilePinFour, versatilePinFive, subcodeStream,
  input wire logic          deemphasisFlag, deemphasisBypass, motorFourLine, audioFeaturesOn, lockToDisc,
  input wire logic          brakeSixPercent, subcodeOn, subcodeThreeWire, quarterRateClock, elevenUnitClock,
  input wire logic          sharedClockOut, sharedClockOe, sixteenUnitClockOe,
  input wire logic [1:0]    loopBandwidthSel, internalBandScale,
  input wire dplc_apb_req_t apbReq,
  input wire dplc_apb_rsp_t apbRsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mirror_q [16];  // What software has stored, by index
  logic [3:0] idx;            // Word index of the current access
  logic       hit;            // Write that lands in a mapped register
  // Decode uses the space chosen before this access, as the bank does
  always_comb begin
    idx = apbReq.paddr[5:2];
    hit = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready
          && apbReq.paddr[7:6] == 2'h0 && apbReq.paddr[1:0] == 2'h0
          && (mirror_q[15][0] ? (idx == 4'h3 || idx == 4'hf) : (idx == 4'h8 || idx >= 4'hc));
  end
  // Mirror starts from the power-on values
  always_ff @(posedge clk) begin
    if (rst) begin
      mirror_q <= '{3: 4'h0, 8: 4'h9, 12: 4'h2, 13: 4'hf, 14: 4'h4, default: 4'h0};
    end else if (hit) begin
      mirror_q[idx] <= apbReq.pwdata[3:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Write that turns the shadow space on
  sequence seqShadowOn;
    hit && idx == 4'hf && apbReq.pwdata[0];
  endsequence
  // Access phase aimed at the off-track and mute register
  sequence seqMainAccess;
    apbReq.psel && apbReq.penable && apbReq.paddr == 8'h30;
  endsequence
  a_zero_wait: assert property (apbReq.psel && apbReq.penable |-> apbRsp.pready)
    else $error("access phase without ready");
  a_shadow_route: assert property (seqMainAccess |-> apbRsp.pslverr == mirror_q[15][0])
    else $error("main register decode does not follow shadow select");
  a_shadow_enter: assert property (seqShadowOn ##[2:4] seqMainAccess |-> apbRsp.pslverr)
    else $error("main register still reachable after shadow select");
  a_offtrack_internal: assert property (!mirror_q[12][0] |-> offTrack == offTrackInternal)
    else $error("off-track not taken from internal source");
  a_mute_select: assert property (muteOut == (mirror_q[12][1] ? muteBoth : muteLeft))
    else $error("mute output carries the wrong flag");
  a_pin_three: assert property (
    versatilePinThreeOe == (mirror_q[3][3] && !(mirror_q[12][1] ? mirror_q[12][2] : muteRight)))
    else $error("shared pin drive enable wrong");
  a_pin_four: assert property (mirror_q[13] != 4'h0 |->
    versatilePinFour == (mirror_q[13][1:0] == 2'h1 ? subcodeStream : &mirror_q[13][1:0]))
    else $error("pin four level wrong");
  a_pin_five: assert property (mirror_q[13] != 4'h0 |->
    versatilePinFive == (mirror_q[13][3:2] == 2'h1 ? deemphasisFlag : &mirror_q[13][3:2]))
    else $error("pin five level wrong");
  a_deemph_bypass: assert property (deemphasisBypass == (mirror_q[13][3:2] == 2'h1))
    else $error("de-emphasis bypass wrong");
  a_motor_mode: assert property (motorFourLine == (mirror_q[13] == 4'h0))
    else $error("four-line motor mode wrong");
  a_clock_pins: assert property (
    sharedClockOut == (mirror_q[3][0] ? elevenUnitClock : quarterRateClock)
    && sharedClockOe == !mirror_q[3][1] && sixteenUnitClockOe == !mirror_q[3][2])
    else $error("clock pin control wrong");
  a_feature_bits: assert property (
    {audioFeaturesOn, lockToDisc, brakeSixPercent, subcodeOn, subcodeThreeWire}
    == {mirror_q[14][3:2] == 2'h1, mirror_q[14][1:0], mirror_q[15][2], mirror_q[15][3]})
    else $error("feature settings wrong");
  a_loop_code: assert property ({internalBandScale, loopBandwidthSel} == mirror_q[8])
    else $error("loop filter code wrong");
  a_reset_values: assert property ($fell(rst) |-> loopBandwidthSel == 2'h1 &&
    internalBandScale == 2'h2 && versatilePinFour && versatilePinFive && audioFeaturesOn)
    else $error("power-on values missing after reset");
endmodule

bind dplc_config_regs dplc_config_regs_asserts dplc_config_regs_asserts_i (.*);
`default_nettype wire

// file: dplc_config_regs_tb_top.sv
// Self-checking testbench for the configuration register bank
`default_nettype none
module dplc_config_regs_tb_top
  import dplc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, versatilePinOne, pinTwoPull, offTrackInternal, muteLeft, muteRight, muteBoth;
  logic motorLineA, motorLineB, subcodeStream, deemphasisFlag, quarterRateClock, elevenUnitClock;
  logic sixteenUnitClock, versatilePinTwoIn, versatilePinThreeOut, versatilePinThreeOe, versatilePinFour;
  logic versatilePinFive, offTrack, muteOut, deemphasisBypass, motorFourLine, audioFeaturesOn, lockToDisc;
  logic brakeSixPercent, subcodeOn, subcodeThreeWire, sharedClockOut, sharedClockOe, sixteenUnitClockOut;
  logic sixteenUnitClockOe;
  logic [1:0]    loopBandwidthSel, internalBandScale;  // Loop filter fields
  dplc_apb_req_t apbReq;                               // Bus request driven here
  dplc_apb_rsp_t apbRsp;                               // Bus answer
  int            errCount, checkCount;                 // Mismatches and comparisons
  // Open-drain wire: pulled up unless the bank pulls it low
  assign versatilePinTwoIn = versatilePinThreeOe ? 1'b0 : pinTwoPull;
  dplc_config_regs dplc_config_regs_i (.*);
  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Count and report one comparison
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chkWord({31'h0, got}, {31'h0, exp});
  endtask
  // Summary line, then verdict
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic apbXfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                         output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 16);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    if (apbRsp.pready !== 1'b1) begin  // Hung slave ends the run
      errCount++;
      printVerdict();
    end
  endtask
  task automatic wrReg(input logic [7:0] addr, input logic [3:0] val);
    logic [31:0] rd;
    logic        err;
    apbXfer(1'b1, addr, {28'h0, val}, rd, err);
    chkBit(err, 1'b0);
  endtask
  task automatic rdReg(input logic [7:0] addr, input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic        err;
    apbXfer(1'b0, addr, 32'h0, rd, err);
    chkWord(rd, exp);
    chkBit(err, expErr);
  endtask
  // Power-on values, read back and at the pins
  task automatic testReset();
    rdReg(8'h20, 32'h9, 1'b0);
    rdReg(8'h30, 32'h2, 1'b0);
    rdReg(8'h34, 32'hf, 1'b0);
    rdReg(8'h38, 32'h4, 1'b0);
    rdReg(8'h3c, 32'h0, 1'b0);
    @(negedge clk);
    chkWord(32'({loopBandwidthSel, internalBandScale, versatilePinFour, versatilePinFive, audioFeaturesOn,
      lockToDisc, brakeSixPercent, subcodeOn, subcodeThreeWire, motorFourLine, deemphasisBypass}), 32'h0dc0);
    chkWord(32'({sharedClockOut, sharedClockOe, sixteenUnitClockOe, sixteenUnitClockOut, offTrack, muteOut,
      versatilePinThreeOe}), 32'h3c);
  endtask
  // Off-track source and mute routing
  task automatic testOffMute();
    wrReg(8'h30, 4'h3);
    versatilePinOne <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chkWord(32'({offTrack, muteOut}), 32'h0);
    wrReg(8'h30, 4'h0);
    @(negedge clk);
    chkWord(32'({offTrack, muteOut}), 32'h3);
    rdReg(8'h40, 32'h2, 1'b0);
    wrReg(8'h30, 4'h6);
    muteBoth <= 1'b1;
    muteLeft <= 1'b0;
    offTrackInternal <= 1'b0;
    @(negedge clk);
    chkWord(32'({muteOut, offTrack, versatilePinThreeOut}), 32'h5);
  endtask
  // Pin four/five selectors, motor mode
  task automatic testMotorPins();
    logic [3:0] codes [5] = '{4'h5, 4'ha, 4'hf, 4'h5, 4'h0};
    logic [1:0] flags [5] = '{2'b10, 2'b00, 2'b00, 2'b01, 2'b00};
    logic [3:0] exps  [5] = '{4'b1010, 4'b0000, 4'b1100, 4'b0110, 4'b1001};
    for (int i = 0; i < 5; i++) begin
      {subcodeStream, deemphasisFlag} <= flags[i];
      wrReg(8'h34, codes[i]);
      @(negedge clk);
      chkWord(32'({versatilePinFour, versatilePinFive, deemphasisBypass, motorFourLine}), 32'(exps[i]));
    end
  endtask
  // Audio, lock, brake and subcode settings
  task automatic testAudioSub();
    wrReg(8'h38, 4'h3);
    wrReg(8'h3c, 4'hc);
    @(negedge clk);
    chkWord(32'({audioFeaturesOn, lockToDisc, brakeSixPercent, subcodeOn, subcodeThreeWire}), 32'h0f);
    wrReg(8'h3c, 4'h4);
    @(negedge clk);
    chkBit(subcodeThreeWire, 1'b0);
    rdReg(8'h38, 32'h3, 1'b0);
  endtask
  // Shadow space in and out; clock pins and open-drain shared pin
  task automatic testShadow();
    wrReg(8'h30, 4'h0);
    wrReg(8'h3c, 4'h1);
    rdReg(8'h30, 32'h0, 1'b1);
    wrReg(8'h0c, 4'hf);
    @(negedge clk);
    chkWord(32'({sharedClockOut, sharedClockOe, sixteenUnitClockOe, versatilePinThreeOe}), 32'h8);
    @(posedge clk);
    muteRight <= 1'b0;
    @(negedge clk);
    chkWord(32'({versatilePinThreeOe, versatilePinThreeOut}), 32'h2);
    repeat (8) @(posedge clk);
    rdReg(8'h40, 32'h4, 1'b0);
    rdReg(8'h0c, 32'hf, 1'b0);
    wrReg(8'h0c, 4'h0);
    wrReg(8'h3c, 4'h0);
    @(negedge clk);
    chkWord(32'({sharedClockOut, sharedClockOe, sixteenUnitClockOe, versatilePinThreeOe}), 32'h6);
    rdReg(8'h20, 32'h9, 1'b0);
    rdReg(8'h0c, 32'h0, 1'b1);
    rdReg(8'h10, 32'h0, 1'b1);
  endtask
  // Reset two cycles, then scenarios
  initial begin
    rst = 1'b1;
    apbReq = '0;
    errCount = 0;
    checkCount = 0;
    {versatilePinOne, pinTwoPull, offTrackInternal, muteLeft, muteRight, muteBoth} = 6'b111110;
    {motorLineA, motorLineB, subcodeStream, deemphasisFlag} = 4'b1010;
    {quarterRateClock, elevenUnitClock, sixteenUnitClock} = 3'b011;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testOffMute();
    testMotorPins();
    testAudioSub();
    testShadow();
    printVerdict();
  end
endmodule
`default_nettype wire
